// *** ans_irq_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ans_map.svh"

module ans_irq_bank #(
   parameter int N = `ANS_IRQ_COUNT
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         clk_en,
   input  wire logic [N-1:0] event_in,
   input  wire logic         clr_wr,
   input  wire logic [N-1:0] clr_data,
   input  wire logic         mask_wr,
   input  wire logic [N-1:0] mask_data,
   output var  logic [N-1:0] status,
   output var  logic [N-1:0] mask,
   output var  logic         irq
);

   logic [N-1:0] status_reg;
   logic [N-1:0] mask_reg;
   logic         irq_reg;
   logic [N-1:0] clr_bits;

   assign clr_bits = clr_wr ? clr_data : '0;

   // set beats a write-one clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_reg <= '0;
      end else if (clk_en) begin
         status_reg <= (status_reg & ~clr_bits) | event_in;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mask_reg <= N'(`ANS_IRQ_MASK_RST);
      end else if (clk_en && mask_wr) begin
         mask_reg <= mask_data;
      end
   end

   // registered, so irq trails the status bit by one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
      end else if (clk_en) begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   assign status = status_reg;
   assign mask   = mask_reg;
   assign irq    = irq_reg;

endmodule : ans_irq_bank

`default_nettype wire

// *** ans_map.svh ***
`ifndef ANS_MAP_SVH
`define ANS_MAP_SVH

// register word indices, byte address is four times the index
`define ANS_IDX_NP_VIEW   6'h05
`define ANS_IDX_EXPANSION 6'h06
`define ANS_IDX_IRQ_STAT  6'h10
`define ANS_IDX_IRQ_MASK  6'h11

// next-page view fields
`define ANS_NP_NEXT     15
`define ANS_NP_ACK      14
`define ANS_NP_MSG_PAGE 13
`define ANS_NP_COMPLY   12
`define ANS_NP_TOGGLE   11
`define ANS_NP_CODE_MSB 10

// expansion register fields
`define ANS_EXP_RSVD_LSB  5
`define ANS_EXP_PD_FAULT  4
`define ANS_EXP_LP_NP     3
`define ANS_EXP_LOCAL_NP  2
`define ANS_EXP_PAGE_RX   1
`define ANS_EXP_LP_AN     0

// interrupt status and mask fields
`define ANS_IRQ_PAGE_RX   0
`define ANS_IRQ_NEXT_PAGE 1
`define ANS_IRQ_PD_FAULT  2
`define ANS_IRQ_COUNT     3

// reset values and the fixed local next-page bit
`define ANS_NP_VIEW_RST  16'h0000
`define ANS_IRQ_MASK_RST 3'h0
`define ANS_LOCAL_NP_VAL 1'b1

`endif

// *** ans_page_capture.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ans_map.svh"

module ans_page_capture (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic        load,
   input  wire logic [15:0] word_in,
   output var  logic [15:0] view
);

   logic [15:0] view_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         view_reg <= `ANS_NP_VIEW_RST;
      end else if (clk_en && load) begin
         view_reg <= word_in;
      end
   end

   assign view = view_reg;

endmodule : ans_page_capture

`default_nettype wire

// *** ans_partner.sv ***
`timescale 1ns/10ps
`default_nettype none

module ans_partner (
   input  wire logic        clk,
   output var  logic        lcw_valid,
   output var  logic        lcw_next,
   output var  logic [15:0] lcw_data,
   output var  logic        pd_fault,
   output var  logic        neg_restart,
   output var  logic        local_extra_pages_supported,
   output var  logic        an_able
);
   initial begin
      lcw_valid   = 1'b0;
      lcw_next    = 1'b0;
      lcw_data    = 16'hFFFF;
      pd_fault    = 1'b0;
      neg_restart = 1'b0;
      local_extra_pages_supported     = 1'b0;
      an_able     = 1'b0;
   end

   task automatic send_page(input logic [15:0] w, input logic nxt);
      @(posedge clk);
      lcw_valid <= 1'b1;
      lcw_next  <= nxt;
      lcw_data  <= w;
      @(posedge clk);
      lcw_valid <= 1'b0;
      // released word shows its inverse, never a stale copy
      lcw_data  <= ~w;
   endtask : send_page

   task automatic pulse(input logic restart);
      @(posedge clk);
      pd_fault    <= ~restart;
      neg_restart <= restart;
      @(posedge clk);
      pd_fault    <= 1'b0;
      neg_restart <= 1'b0;
   endtask : pulse

   task automatic set_abilities(input logic np, input logic an);
      @(posedge clk);
      local_extra_pages_supported <= np;
      an_able <= an;
   endtask : set_abilities
endmodule : ans_partner

`default_nettype wire

// *** ans_pkg.sv ***
`default_nettype none

package ans_pkg;

   typedef enum logic [0:0] {
      ANS_IDLE = 1'b0,
      ANS_RESP = 1'b1
   } ans_apb_state_type;

   typedef enum logic [2:0] {
      ANS_SEL_NONE = 3'h0,
      ANS_SEL_NPV  = 3'h1,
      ANS_SEL_EXP  = 3'h2,
      ANS_SEL_STAT = 3'h3,
      ANS_SEL_MASK = 3'h4
   } ans_reg_sel_type;

endpackage : ans_pkg

`default_nettype wire

// *** ans_status.sv ***
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "ans_map.svh"
// Notes on behaviour
// - ack bit set only from received pages
// - bit 13 message page, 10:0 code
// - bit 12 partner can comply with message
// - bit 11 toggle of received page
// - expansion bits 15:5 zero, writes ignored
// - bit 4 sticky parallel detection fault
// - bit 3 partner supports next pages
// - bit 2 fixed one, local next pages
// - bit 1 set on page, clear on read
// - bit 0 partner can auto-negotiate

module ans_status
   import ans_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        lcw_valid,
   input  wire logic        lcw_next,
   input  wire logic [15:0] lcw_data,
   input  wire logic        pd_fault,
   input  wire logic        neg_restart,
   input  wire logic        partner_local_extra_pages_supported_in,
   input  wire logic        partner_an_able_in,
   output var  logic        irq
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   ans_apb_state_type state_reg;
   ans_apb_state_type state_next;
   logic [31:0]       prdata_reg;
   logic [31:0]       rd_mux;
   logic              pready_reg;
   logic              pslverr_reg;
   logic              irq_w;
   logic              irq_reg;
   logic              apb_done;
   logic              wr_done;
   logic              rd_done;
   ans_reg_sel_type   sel_now;
   logic              np_load;
   logic [15:0]       npv_word;
   logic              pdf_reg;
   logic              lp_np_reg;
   logic              lp_an_reg;
   logic              page_rx_reg;
   logic              page_rx_clr;
   logic [15:0]       exp_word;
   logic [`ANS_IRQ_COUNT-1:0] irq_events;
   logic [`ANS_IRQ_COUNT-1:0] irq_status;
   logic [`ANS_IRQ_COUNT-1:0] irq_mask;

   function automatic ans_reg_sel_type ans_decode(
      input logic [7:0] a
   );
      ans_reg_sel_type s;
      s = ANS_SEL_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[7:2])
            `ANS_IDX_NP_VIEW:   s = ANS_SEL_NPV;
            `ANS_IDX_EXPANSION: s = ANS_SEL_EXP;
            `ANS_IDX_IRQ_STAT:  s = ANS_SEL_STAT;
            `ANS_IDX_IRQ_MASK:  s = ANS_SEL_MASK;
            default:            s = ANS_SEL_NONE;
         endcase
      end
      return s;
   endfunction : ans_decode

   assign sel_now  = ans_decode(paddr);
   // the edge where pready is seen high completes the transfer
   assign apb_done = psel && penable && pready_reg;
   assign wr_done  = apb_done && pwrite;
   assign rd_done  = apb_done && !pwrite;

   // ---------------- APB slave, one wait state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ANS_IDLE: begin
            if (psel && penable) begin
               state_next = ANS_RESP;
            end
         end
         ANS_RESP: begin
            state_next = ANS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ANS_IDLE;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_reg <= 1'b0;
      end else if (clk_en) begin
         pready_reg <= (state_next == ANS_RESP);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (sel_now)
         ANS_SEL_NPV:  rd_mux = {16'h0000, npv_word};
         ANS_SEL_EXP:  rd_mux = {16'h0000, exp_word};
         ANS_SEL_STAT: rd_mux = 32'(irq_status);
         ANS_SEL_MASK: rd_mux = 32'(irq_mask);
         ANS_SEL_NONE: rd_mux = 32'h0000_0000;
      endcase
   end

   // data and error are latched as pready rises
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == ANS_IDLE && psel && penable) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_reg <= (sel_now == ANS_SEL_NONE);
         end else if (state_reg == ANS_RESP) begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // ---------------- next-page view
   // only received pages load it
   assign np_load = lcw_valid && lcw_next;

   ans_page_capture u_page (
      .clk     (clk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .load    (np_load),
      .word_in (lcw_data),
      .view    (npv_word)
   );

   // ---------------- expansion register
   // upper bits tied to zero
   assign exp_word = {11'h000, pdf_reg, lp_np_reg,
                      `ANS_LOCAL_NP_VAL, page_rx_reg, lp_an_reg};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pdf_reg <= 1'b0;
      end else if (clk_en) begin
         if (pd_fault) begin
            pdf_reg <= 1'b1;
         end else if (neg_restart) begin
            pdf_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lp_np_reg <= 1'b0;
      end else if (clk_en) begin
         lp_np_reg <= partner_local_extra_pages_supported_in;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lp_an_reg <= 1'b0;
      end else if (clk_en) begin
         lp_an_reg <= partner_an_able_in;
      end
   end

   // clear only a flag that was reported
   // so a page landing during the read survives
   assign page_rx_clr = rd_done && (sel_now == ANS_SEL_EXP)
                        && prdata_reg[`ANS_EXP_PAGE_RX];

   // set on page, clear on read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         page_rx_reg <= 1'b0;
      end else if (clk_en) begin
         if (lcw_valid) begin
            page_rx_reg <= 1'b1;
         end else if (page_rx_clr) begin
            page_rx_reg <= 1'b0;
         end
      end
   end

   // ---------------- interrupts
   always_comb begin
      irq_events = '0;
      irq_events[`ANS_IRQ_PAGE_RX]   = lcw_valid;
      irq_events[`ANS_IRQ_NEXT_PAGE] = np_load;
      irq_events[`ANS_IRQ_PD_FAULT]  = pd_fault;
   end

   ans_irq_bank #(
      .N (`ANS_IRQ_COUNT)
   ) u_irq (
      .clk       (clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .event_in  (irq_events),
      .clr_wr    (wr_done && sel_now == ANS_SEL_STAT),
      .clr_data  (pwdata[`ANS_IRQ_COUNT-1:0]),
      .mask_wr   (wr_done && sel_now == ANS_SEL_MASK),
      .mask_data (pwdata[`ANS_IRQ_COUNT-1:0]),
      .status    (irq_status),
      .mask      (irq_mask),
      .irq       (irq_w)
   );

   // irq_w already leaves a flip-flop inside the bank
   always_comb begin
      irq_reg = irq_w;
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq     = irq_reg;

   // ---------------- checks
   sequence np_page_seq;
      clk_en && lcw_valid && lcw_next;
   endsequence

   sequence npv_write_seq;
      clk_en && wr_done && sel_now == ANS_SEL_NPV && !np_load;
   endsequence

   sequence exp_read_seq;
      clk_en && state_reg == ANS_IDLE && psel && penable
      && !pwrite && sel_now == ANS_SEL_EXP;
   endsequence

   sequence exp_clear_seq;
      clk_en && page_rx_clr && !lcw_valid;
   endsequence

   npv_sw_write_a : assert property (
      npv_write_seq |=> $stable(npv_word))
      else $error("software write changed next-page view");

   npv_msg_code_a : assert property (
      np_page_seq |=> npv_word[`ANS_NP_MSG_PAGE] ==
         $past(lcw_data[`ANS_NP_MSG_PAGE])
      && npv_word[`ANS_NP_CODE_MSB:0] ==
         $past(lcw_data[`ANS_NP_CODE_MSB:0]))
      else $error("message flag or code not captured");

   npv_comply_a : assert property (
      np_page_seq |=> npv_word[`ANS_NP_COMPLY] ==
         $past(lcw_data[`ANS_NP_COMPLY]))
      else $error("comply bit not captured");

   npv_toggle_a : assert property (
      np_page_seq |=> npv_word[`ANS_NP_TOGGLE] ==
         $past(lcw_data[`ANS_NP_TOGGLE]))
      else $error("toggle bit not captured");

   npv_whole_a : assert property (
      np_page_seq |=> npv_word == $past(lcw_data)
      ##1 (np_load || $stable(npv_word)))
      else $error("next-page view not loaded as one word");

   exp_rsvd_zero_a : assert property (
      exp_read_seq |=> pready_reg
      && prdata_reg[31:`ANS_EXP_RSVD_LSB] == 27'h0000000)
      else $error("expansion reserved bits not zero");

   pdf_sticky_a : assert property (
      clk_en && pd_fault |=> pdf_reg
      ##1 (pdf_reg || $past(neg_restart)))
      else $error("parallel fault flag not sticky");

   lp_np_follow_a : assert property (
      clk_en |=> lp_np_reg == $past(partner_local_extra_pages_supported_in))
      else $error("partner next-page bit wrong");

   local_np_one_a : assert property (
      exp_read_seq |=> prdata_reg[`ANS_EXP_LOCAL_NP] == 1'b1)
      else $error("local next-page bit not one");

   page_rx_set_a : assert property (
      clk_en && lcw_valid |=> page_rx_reg)
      else $error("page received flag not set");

   page_rx_cor_a : assert property (
      exp_clear_seq |=> !page_rx_reg)
      else $error("page received flag not cleared on read");

   lp_an_follow_a : assert property (
      clk_en |=> lp_an_reg == $past(partner_an_able_in))
      else $error("partner negotiation bit wrong");

   apb_one_wait_a : assert property (
      clk_en && psel && penable && !pready_reg
      |=> pready_reg)
      else $error("pready not raised after one wait");

endmodule : ans_status

`default_nettype wire

// *** tb_autoneg_next_page_expansion_status.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_autoneg_next_page_expansion_status;
   logic        clk;
   logic        resetn;
   logic        clk_en;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        lcw_valid;
   logic        lcw_next;
   logic [15:0] lcw_data;
   logic        pd_fault;
   logic        neg_restart;
   logic        local_extra_pages_supported;
   logic        an_able;
   logic        irq;
   int          errors;
   int          total_checks;

   ans_status uut (
      .clk(clk), .resetn(resetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .lcw_valid(lcw_valid), .lcw_next(lcw_next), .lcw_data(lcw_data),
      .pd_fault(pd_fault), .neg_restart(neg_restart),
      .partner_local_extra_pages_supported_in(local_extra_pages_supported), .partner_an_able_in(an_able),
      .irq(irq)
   );

   ans_partner partner (
      .clk(clk), .lcw_valid(lcw_valid), .lcw_next(lcw_next),
      .lcw_data(lcw_data), .pd_fault(pd_fault),
      .neg_restart(neg_restart), .local_extra_pages_supported(local_extra_pages_supported), .an_able(an_able)
   );

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic experr);
      logic [31:0] v;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, v, e);
      chk_word(v, exp);
      chk_bit(e, experr);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic        e;
      apb(1'b1, a, d, v, e);
      chk_bit(e, 1'b0);
   endtask : wr

   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clk);
      chk_bit(irq, exp);
   endtask : irq_is

   initial begin
      errors = 0;
      total_checks = 0;
      resetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h18, 32'h0000_0004, 1'b0);
      rd(8'h14, 32'h0000_0000, 1'b0);
      rd(8'h40, 32'h0000_0000, 1'b0);
      rd(8'h44, 32'h0000_0000, 1'b0);
      chk_bit(irq, 1'b0);
      wr(8'h18, 32'hFFFF_FFFF);
      rd(8'h18, 32'h0000_0004, 1'b0);
      partner.set_abilities(1'b1, 1'b1);
      rd(8'h18, 32'h0000_000D, 1'b0);
      partner.send_page(16'h3ABC, 1'b1);
      rd(8'h14, 32'h0000_3ABC, 1'b0);
      rd(8'h18, 32'h0000_000F, 1'b0);
      rd(8'h18, 32'h0000_000D, 1'b0);
      wr(8'h14, 32'h0000_FFFF);
      rd(8'h14, 32'h0000_3ABC, 1'b0);
      partner.send_page(16'h4155, 1'b1);
      rd(8'h14, 32'h0000_4155, 1'b0);
      rd(8'h40, 32'h0000_0003, 1'b0);
      irq_is(1'b0);
      wr(8'h44, 32'h0000_0007);
      rd(8'h44, 32'h0000_0007, 1'b0);
      irq_is(1'b1);
      wr(8'h40, 32'h0000_0003);
      rd(8'h40, 32'h0000_0000, 1'b0);
      irq_is(1'b0);
      partner.pulse(1'b0);
      rd(8'h18, 32'h0000_001F, 1'b0);
      rd(8'h18, 32'h0000_001D, 1'b0);
      rd(8'h40, 32'h0000_0004, 1'b0);
      irq_is(1'b1);
      partner.pulse(1'b1);
      rd(8'h18, 32'h0000_000D, 1'b0);
      partner.set_abilities(1'b0, 1'b0);
      rd(8'h18, 32'h0000_0004, 1'b0);
      // frozen clock enable drops a page entirely
      wr(8'h40, 32'h0000_0007);
      clk_en <= 1'b0;
      partner.send_page(16'h7FFF, 1'b1);
      clk_en <= 1'b1;
      // base page: flag only, view untouched
      partner.send_page(16'h1234, 1'b0);
      rd(8'h14, 32'h0000_4155, 1'b0);
      rd(8'h40, 32'h0000_0001, 1'b0);
      rd(8'h18, 32'h0000_0006, 1'b0);
      irq_is(1'b1);
      // unmapped and unaligned places answer with an error
      rd(8'h20, 32'h0000_0000, 1'b1);
      rd(8'h15, 32'h0000_0000, 1'b1);
      wrap_up();
   end
endmodule : tb_autoneg_next_page_expansion_status

`default_nettype wire
